//--- hdl/asu_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "asu_defines.svh"

module asu_top (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Register port
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rdata,
  // Serial pins
  input  wire logic       serial_in,
  output logic            tx_pin,
  output logic            tx_pin_oe_n,
  // Processor interrupt mask and request
  input  wire logic       irq_mask,
  output logic            irq
);

  asu_pkg::asu_tx_state_type tx_state;
  asu_pkg::asu_rx_state_type rx_state;
  asu_pkg::asu_frame_type    next_kind;
  asu_pkg::asu_frame_type    cur_kind;

  logic [7:0]  rate;
  logic [7:0]  ctl2;
  logic        tx_ninth_bit, rx_ninth_bit, word9, wake_addr;
  logic        seq_armed;
  logic        tx_tick, rx_tick;
  // Transmit side
  logic [10:0] tx_shift, load_frame;
  logic [3:0]  tx_cnt, tx_left, load_len, frame_len;
  logic [7:0]  tx_hold;
  logic        tx_buf_empty, tx_done, idle_pend, brk_last, tx_on_q;
  logic        frame_end, direct, tx_load, tx_rise;
  // Receive side
  logic        rx_meta, rx_line;
  logic [3:0]  rx_cnt, rx_idx;
  logic [8:0]  rx_shift;
  logic [1:0]  rx_smp;
  logic        rx_bit, rx_noisy, noise_acc;
  logic [7:0]  idle_cnt, idle_lim;
  logic        char_ev, char_ninth, char_ferr, char_noise, idle_ev;
  logic [7:0]  char_data, rx_holding;
  logic        rx_full, overrun, noise_flag, frame_err, idle_flag;
  logic        idle_armed, accept, wake;
  logic        wr_data_seq, rd_data_seq;

  wire tx_on   = ctl2[`ASU_C2_TXON];
  wire rx_on   = ctl2[`ASU_C2_RXON];
  wire mute_rx = ctl2[`ASU_C2_MUTE];
  wire send_break = ctl2[`ASU_C2_BRK];

  function automatic logic maj3(logic a, logic b, logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction

  function automatic logic [10:0] data_frame(logic w9, logic n9,
                                             logic [7:0] d);
    return w9 ? {1'b1, n9, d, 1'b0} : {2'b11, d, 1'b0};
  endfunction

  // Independent generators for each direction
  asu_rate_gen u_tx_rate (
    .clk       (clk),
    .resetn    (resetn),
    .base_code (rate[`ASU_RT_BASE]),
    .step_code (rate[`ASU_RT_TXDIV]),
    .tick      (tx_tick)
  );

  asu_rate_gen u_rx_rate (
    .clk       (clk),
    .resetn    (resetn),
    .base_code (rate[`ASU_RT_BASE]),
    .step_code (rate[`ASU_RT_RXDIV]),
    .tick      (rx_tick)
  );

  // Status read arms the clear; the next data access consumes it
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      seq_armed <= 1'b0;
    else if (rd_stb && addr == `ASU_ADDR_FLAG)
      seq_armed <= 1'b1;
    else if ((rd_stb || wr_stb) && addr == `ASU_ADDR_DATA)
      seq_armed <= 1'b0;
  end

  assign wr_data_seq = wr_stb && addr == `ASU_ADDR_DATA && seq_armed;
  assign rd_data_seq = rd_stb && addr == `ASU_ADDR_DATA && seq_armed;

  // Read data stand for exactly one cycle after the strobe
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdata <= 8'h00;
    else if (!rd_stb)
      rdata <= 8'h00;
    else
      unique case (addr)
        `ASU_ADDR_FLAG: rdata <= {tx_buf_empty, tx_done, rx_full, idle_flag,
                                  overrun, noise_flag, frame_err, 1'b0};
        `ASU_ADDR_DATA: rdata <= rx_holding;
        `ASU_ADDR_RATE: rdata <= rate;
        `ASU_ADDR_CTL1: rdata <= {rx_ninth_bit, tx_ninth_bit, 1'b0, word9,
                                  wake_addr, 3'h0};
        `ASU_ADDR_CTL2: rdata <= ctl2;
        default:        rdata <= 8'h00;
      endcase
  end

  // Rate and word-format controls; rates should only change while off
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rate         <= `ASU_RST_RATE;
      tx_ninth_bit <= 1'b0;
      word9        <= 1'b0;
      wake_addr    <= 1'b0;
    end
    else if (wr_stb && addr == `ASU_ADDR_RATE)
      rate <= wdata;
    else if (wr_stb && addr == `ASU_ADDR_CTL1)
    begin
      tx_ninth_bit <= wdata[`ASU_C1_TX9];
      word9        <= wdata[`ASU_C1_WORD9];
      wake_addr    <= wdata[`ASU_C1_WAKE];
    end
  end

  // Control two; hardware wake clears mute and beats a write to it
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ctl2 <= `ASU_RST_CTL;
    else
    begin
      if (wr_stb && addr == `ASU_ADDR_CTL2)
        ctl2 <= wdata;
      if (wake)
        ctl2[`ASU_C2_MUTE] <= 1'b0;
    end
  end

  // Transmit frame selection
  assign frame_len = word9 ? `ASU_LEN9 : `ASU_LEN8;
  assign frame_end = tx_state == asu_pkg::TX_SEND && tx_tick &&
                     tx_cnt == `ASU_LAST_TICK && tx_left == 4'h1;
  assign tx_rise   = tx_on && !tx_on_q;
  assign direct    = wr_data_seq && tx_state == asu_pkg::TX_READY &&
                     tx_on && !idle_pend && !send_break && !brk_last &&
                     tx_buf_empty;

  always_comb
  begin
    next_kind  = asu_pkg::FR_NONE;
    load_frame = 11'h7ff;
    load_len   = frame_len;
    if (direct)
    begin
      next_kind  = asu_pkg::FR_DATA;
      load_frame = data_frame(word9, tx_ninth_bit, wdata);
    end
    else if (!tx_on)
      next_kind = asu_pkg::FR_NONE;
    else if (idle_pend)
      next_kind = asu_pkg::FR_IDLE;
    else if (send_break)
    begin
      next_kind  = asu_pkg::FR_BREAK;
      load_frame = 11'h000;
    end
    else if (brk_last)
    begin
      next_kind = asu_pkg::FR_MARK;
      load_len  = 4'h1;
    end
    else if (!tx_buf_empty)
    begin
      next_kind  = asu_pkg::FR_DATA;
      load_frame = data_frame(word9, tx_ninth_bit, tx_hold);
    end
  end

  assign tx_load = direct || (next_kind != asu_pkg::FR_NONE &&
                   (tx_state == asu_pkg::TX_READY || frame_end));

  // Transmit state and shifter
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_state <= asu_pkg::TX_OFF;
      cur_kind <= asu_pkg::FR_NONE;
      tx_shift <= 11'h7ff;
      tx_cnt   <= 4'h0;
      tx_left  <= 4'h0;
    end
    else if (tx_load)
    begin
      tx_state <= asu_pkg::TX_SEND;
      cur_kind <= next_kind;
      tx_shift <= load_frame;
      tx_cnt   <= 4'h0;
      tx_left  <= load_len;
    end
    else
      unique case (tx_state)
        asu_pkg::TX_OFF:
          if (tx_on)
            tx_state <= asu_pkg::TX_READY;
        asu_pkg::TX_READY:
          if (!tx_on)
            tx_state <= asu_pkg::TX_OFF;
        asu_pkg::TX_SEND:
          if (frame_end)
            tx_state <= tx_on ? asu_pkg::TX_READY : asu_pkg::TX_OFF;
          else if (tx_tick)
          begin
            tx_cnt <= tx_cnt + 4'h1;
            if (tx_cnt == `ASU_LAST_TICK)
            begin
              tx_shift <= {1'b1, tx_shift[10:1]};
              tx_left  <= tx_left - 4'h1;
            end
          end
      endcase
  end

  // Pin handed to the port function whenever the transmitter is off
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_pin      <= 1'b1;
      tx_pin_oe_n <= 1'b1;
    end
    else
    begin
      tx_pin      <= tx_state == asu_pkg::TX_SEND ? tx_shift[0] : 1'b1;
      tx_pin_oe_n <= tx_state == asu_pkg::TX_OFF;
    end
  end

  // Transmit flags and holding word
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_on_q      <= 1'b0;
      idle_pend    <= 1'b0;
      brk_last     <= 1'b0;
      tx_buf_empty <= 1'b1;
      tx_done      <= 1'b1;
      tx_hold      <= 8'h00;
    end
    else
    begin
      tx_on_q <= tx_on;
      if (tx_rise)
        idle_pend <= 1'b1;
      else if (tx_load && next_kind == asu_pkg::FR_IDLE)
        idle_pend <= 1'b0;
      if (tx_load)
        brk_last <= next_kind == asu_pkg::FR_BREAK;
      // Re-enable mid frame drops the waiting word
      if (tx_rise && tx_state != asu_pkg::TX_OFF)
        tx_buf_empty <= 1'b1;
      else if (wr_data_seq && !direct)
      begin
        tx_buf_empty <= 1'b0;
        tx_hold      <= wdata;
      end
      else if (tx_load && !direct && next_kind == asu_pkg::FR_DATA)
        tx_buf_empty <= 1'b1;
      // Set wins over the software clear
      if (frame_end && cur_kind != asu_pkg::FR_MARK)
        tx_done <= 1'b1;
      else if (wr_data_seq)
        tx_done <= 1'b0;
    end
  end

  // Two-flop synchroniser on the serial input
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_meta <= 1'b1;
      rx_line <= 1'b1;
    end
    else
    begin
      rx_meta <= serial_in;
      rx_line <= rx_meta;
    end
  end

  assign rx_bit   = maj3(rx_smp[1], rx_smp[0], rx_line);
  assign rx_noisy = !(rx_smp[1] == rx_smp[0] && rx_smp[0] == rx_line);
  assign idle_lim = 8'({4'h0, frame_len} << 4);

  // Receive sampler; one tick of phase error against the start edge
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_state  <= asu_pkg::RX_HUNT;
      rx_cnt    <= 4'h0;
      rx_idx    <= 4'h0;
      rx_shift  <= 9'h000;
      rx_smp    <= 2'h3;
      noise_acc <= 1'b0;
      idle_cnt  <= 8'h00;
      char_ev   <= 1'b0;
      char_ferr <= 1'b0;
      char_noise <= 1'b0;
      idle_ev   <= 1'b0;
    end
    else
    begin
      char_ev <= 1'b0;
      idle_ev <= 1'b0;
      if (!rx_on)
      begin
        rx_state <= asu_pkg::RX_HUNT;
        idle_cnt <= 8'h00;
      end
      else if (rx_tick)
      begin
        rx_cnt <= rx_cnt + 4'h1;
        if (rx_cnt == `ASU_SMP_A || rx_cnt == `ASU_SMP_B)
          rx_smp <= {rx_smp[0], rx_line};
        unique case (rx_state)
          asu_pkg::RX_HUNT:
          begin
            idle_cnt <= rx_line ? idle_cnt + 8'h01 : 8'h00;
            if (rx_line && idle_cnt == idle_lim - 8'h01)
              idle_ev <= 1'b1;
            if (!rx_line)
            begin
              rx_state  <= asu_pkg::RX_START;
              rx_cnt    <= 4'h1;
              noise_acc <= 1'b0;
            end
          end
          asu_pkg::RX_START:
            if (rx_cnt == `ASU_SMP_C)
            begin
              noise_acc <= rx_noisy;
              if (rx_bit)
                rx_state <= asu_pkg::RX_HUNT;        // False start
            end
            else if (rx_cnt == `ASU_LAST_TICK)
            begin
              rx_state <= asu_pkg::RX_DATA;
              rx_idx   <= 4'h0;
            end
          asu_pkg::RX_DATA:
            if (rx_cnt == `ASU_SMP_C)
            begin
              if (rx_idx == (word9 ? `ASU_BITS9 : `ASU_BITS8))
              begin
                rx_state   <= asu_pkg::RX_HUNT;
                idle_cnt   <= 8'h00;
                char_ev    <= 1'b1;
                char_ferr  <= !rx_bit;
                char_noise <= noise_acc | rx_noisy;
              end
              else
              begin
                rx_shift  <= {rx_bit, rx_shift[8:1]};
                rx_idx    <= rx_idx + 4'h1;
                noise_acc <= noise_acc | rx_noisy;
              end
            end
        endcase
      end
    end
  end

  assign char_data  = word9 ? rx_shift[7:0] : rx_shift[8:1];
  assign char_ninth = word9 & rx_shift[8];
  // Muted receiver takes only an address mark when so configured
  assign accept = !mute_rx || (wake_addr &&
                  (word9 ? char_ninth : char_data[7]));
  assign wake   = mute_rx && ((char_ev && accept) ||
                  (idle_ev && !wake_addr && idle_armed));

  // Receive flags; a new event beats the software clear
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_full      <= 1'b0;
      overrun      <= 1'b0;
      noise_flag   <= 1'b0;
      frame_err    <= 1'b0;
      idle_flag    <= 1'b0;
      idle_armed   <= 1'b1;
      rx_holding   <= 8'h00;
      rx_ninth_bit <= 1'b0;
    end
    else if (!rx_on)
    begin
      rx_full    <= 1'b0;
      overrun    <= 1'b0;
      noise_flag <= 1'b0;
      frame_err  <= 1'b0;
      idle_flag  <= 1'b0;
    end
    else
    begin
      if (rd_data_seq)
      begin
        rx_full    <= 1'b0;
        overrun    <= 1'b0;
        noise_flag <= 1'b0;
        frame_err  <= 1'b0;
        idle_flag  <= 1'b0;
      end
      if (char_ev && accept)
      begin
        idle_armed <= 1'b1;
        if (rx_full && !rd_data_seq)
          overrun <= 1'b1;
        else
        begin
          rx_full      <= 1'b1;
          rx_holding   <= char_data;
          rx_ninth_bit <= char_ninth;
          noise_flag   <= char_noise;
          frame_err    <= char_ferr;
        end
      end
      if (idle_ev && idle_armed && !mute_rx)
      begin
        idle_flag  <= 1'b1;
        idle_armed <= 1'b0;
      end
      else if (wake && idle_ev)
        idle_armed <= 1'b0;
    end
  end

  // One request line; noise and framing add no source of their own
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      irq <= 1'b0;
    else
      irq <= !irq_mask && (
             (tx_buf_empty && ctl2[`ASU_C2_TXE_IRQ]) ||
             (tx_done && ctl2[`ASU_C2_TXD_IRQ]) ||
             ((rx_full || overrun) && ctl2[`ASU_C2_RX_IRQ]) ||
             (idle_flag && ctl2[`ASU_C2_IDLE_IRQ]));
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_pin_released: assert property (
    tx_state == asu_pkg::TX_OFF |=> tx_pin_oe_n)
    else $error("pin not released while off");
  a_idle_first: assert property (
    tx_rise && tx_state == asu_pkg::TX_OFF
    |=> tx_load && next_kind == asu_pkg::FR_IDLE)
    else $error("no idle frame after enable");
  a_start_low: assert property (
    tx_load && next_kind == asu_pkg::FR_DATA |=> ##1 !tx_pin)
    else $error("data frame without low start bit");
  a_direct_load: assert property (
    direct |=> tx_state == asu_pkg::TX_SEND && tx_buf_empty)
    else $error("direct write did not start frame");
  a_seq_clear: assert property (
    wr_data_seq && !direct && !frame_end && !tx_rise
    |=> !tx_buf_empty && !tx_done)
    else $error("write sequence did not clear flags");
  a_rx_load: assert property (
    rx_on && char_ev && accept && !rx_full
    |=> rx_full && rx_holding == $past(char_data))
    else $error("character not moved to holding");
  a_rx_overrun: assert property (
    rx_on && char_ev && accept && rx_full && !rd_data_seq
    |=> overrun && $stable(rx_holding))
    else $error("overrun not flagged or holding changed");
  a_rx_clear: assert property (
    rx_on && rd_data_seq && !char_ev |=> !rx_full && !overrun)
    else $error("read sequence did not clear receive flags");
  a_irq_gate: assert property (
    irq_mask |=> !irq)
    else $error("interrupt while globally masked");

  c_data_sent: cover property (frame_end && cur_kind == asu_pkg::FR_DATA);
  c_break_mark: cover property (tx_load && next_kind == asu_pkg::FR_MARK);
  c_overrun: cover property (char_ev && rx_full && rx_on);
  c_idle_seen: cover property (idle_ev && rx_on);

endmodule // asu_top

`default_nettype wire

//--- include/asu_defines.svh
`ifndef ASU_DEFINES_SVH
`define ASU_DEFINES_SVH

// Register offsets
`define ASU_ADDR_FLAG   3'h0
`define ASU_ADDR_DATA   3'h1
`define ASU_ADDR_RATE   3'h2
`define ASU_ADDR_CTL1   3'h3
`define ASU_ADDR_CTL2   3'h4

// control_one fields
`define ASU_C1_RX9      7
`define ASU_C1_TX9      6
`define ASU_C1_WORD9    4
`define ASU_C1_WAKE     3

// control_two fields
`define ASU_C2_TXE_IRQ  7
`define ASU_C2_TXD_IRQ  6
`define ASU_C2_RX_IRQ   5
`define ASU_C2_IDLE_IRQ 4
`define ASU_C2_TXON     3
`define ASU_C2_RXON     2
`define ASU_C2_MUTE     1
`define ASU_C2_BRK      0

// rate_divider fields
`define ASU_RT_BASE     7:6
`define ASU_RT_TXDIV    5:3
`define ASU_RT_RXDIV    2:0

// Reset values
`define ASU_RST_CTL     8'h00
`define ASU_RST_RATE    8'h00

// Base prescaler values for codes 0..3
`define ASU_BASE_0      4'h1
`define ASU_BASE_1      4'h3
`define ASU_BASE_2      4'h4
`define ASU_BASE_3      4'hd

// Timing: 32 clocks per bit at unit division, 16 samples per bit
`define ASU_CLKS_PER_BIT 12'h020
`define ASU_OVERSAMPLE   12'h010
`define ASU_CLK_PER_TICK (`ASU_CLKS_PER_BIT / `ASU_OVERSAMPLE)
`define ASU_SMP_A        4'h7
`define ASU_SMP_B        4'h8
`define ASU_SMP_C        4'h9
`define ASU_LAST_TICK    4'hf

// Frame lengths in bits
`define ASU_LEN8        4'ha
`define ASU_LEN9        4'hb
`define ASU_BITS8       4'h8
`define ASU_BITS9       4'h9

`endif

//--- include/asu_pkg.sv
package asu_pkg;

  typedef enum logic [1:0] {
    TX_OFF   = 2'b00,
    TX_READY = 2'b01,
    TX_SEND  = 2'b11
  } asu_tx_state_type;

  typedef enum logic [1:0] {
    RX_HUNT  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b11
  } asu_rx_state_type;

  typedef enum logic [2:0] {
    FR_NONE  = 3'h0,
    FR_IDLE  = 3'h1,
    FR_BREAK = 3'h2,
    FR_MARK  = 3'h3,
    FR_DATA  = 3'h4
  } asu_frame_type;

endpackage

//--- hdl/asu_rate_gen.sv
`timescale 1ns/100ps
`default_nettype none
`include "asu_defines.svh"

module asu_rate_gen (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Rate selection
  input  wire logic [1:0] base_code,
  input  wire logic [2:0] step_code,
  // Oversample strobe, sixteen per bit
  output logic            tick
);

  logic [11:0] count;
  logic [11:0] limit;

  // Clocks per tick minus one: 2 * base * 2^step, at most 3328
  function automatic logic [11:0] limit_of(logic [1:0] b, logic [2:0] s);
    logic [11:0] base;
    base = 12'h000;
    unique case (b)
      2'h0: base = {8'h00, `ASU_BASE_0};
      2'h1: base = {8'h00, `ASU_BASE_1};
      2'h2: base = {8'h00, `ASU_BASE_2};
      2'h3: base = {8'h00, `ASU_BASE_3};
    endcase
    return 12'((base * 12'(`ASU_CLK_PER_TICK)) << s) - 12'h001;
  endfunction

  assign limit = limit_of(base_code, step_code);

  // Compare with >= so a lowered limit never strands the counter
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      count <= 12'h000;
      tick  <= 1'b0;
    end
    else if (count >= limit)
    begin
      count <= 12'h000;
      tick  <= 1'b1;
    end
    else
    begin
      count <= count + 12'h001;
      tick  <= 1'b0;
    end
  end

endmodule // asu_rate_gen

`default_nettype wire

//--- bench/asu_line_partner.sv
`timescale 1ns/100ps
`default_nettype none

// Far-end equipment: sends frames on demand, captures the device's frames
module asu_line_partner #(
  parameter int BIT_CLKS = 32
) (
  // Clock
  input  wire logic       clk,
  // Send side
  input  wire logic       send,
  input  wire logic [7:0] send_data,
  input  wire logic       send_stop,
  output logic            line,
  // Capture side
  input  wire logic       tx_line,
  output logic      [9:0] got,
  output logic            got_stb
);
  logic [9:0] sbits;
  logic [9:0] rbits;

  initial line = 1'b1;
  initial got_stb = 1'b0;
  initial got = 10'h000;

  // Low stop with zero data makes a break frame
  always @(posedge clk)
  begin
    if (send)
    begin
      sbits = {send_stop, send_data, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
        line <= sbits[i];
        repeat (BIT_CLKS) @(posedge clk);
      end
      line <= 1'b1; // Idle high between frames
    end
  end

  // Mid-bit sampling, start bit kept in bit 0
  always @(posedge clk)
  begin
    if (tx_line === 1'b0)
    begin
      repeat (BIT_CLKS / 2) @(posedge clk);
      rbits[0] = tx_line;
      for (int i = 1; i < 10; i++)
      begin
        repeat (BIT_CLKS) @(posedge clk);
        rbits[i] = tx_line;
      end
      got <= rbits;
      got_stb <= 1'b1;
      @(posedge clk);
      got_stb <= 1'b0;
    end
  end
endmodule // asu_line_partner

`default_nettype wire

//--- bench/asu_top_test.sv
`timescale 1ns/100ps
`default_nettype none

module asu_top_test;
  // Design and partner signals
  logic        clk;
  logic        resetn;
  logic  [2:0] addr;
  logic  [7:0] wdata;
  logic        wr_stb;
  logic        rd_stb;
  logic  [7:0] rdata;
  logic        serial_in;
  logic        tx_pin;
  logic        tx_pin_oe_n;
  logic        irq_mask;
  logic        irq;
  logic        send;
  logic  [7:0] send_data;
  logic        send_stop;
  logic  [9:0] got;
  logic        got_stb;
  logic        tx_line;
  // Bench model state
  logic [31:0] seed;
  logic  [7:0] rx_q[$];
  int          bad_count = 0;
  int          checked = 0;
  int          cyc = 0;
  int          lows;

  // Pull-up holds the line once the pin is handed back
  assign tx_line = tx_pin_oe_n ? 1'b1 : tx_pin;

  asu_top dut_u (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .serial_in(serial_in),
    .tx_pin(tx_pin), .tx_pin_oe_n(tx_pin_oe_n), .irq_mask(irq_mask),
    .irq(irq));
  asu_line_partner partner_u (.clk(clk), .send(send), .send_data(send_data),
    .send_stop(send_stop), .line(serial_in), .tx_line(tx_line), .got(got),
    .got_stb(got_stb));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Cuts a hang short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      results();
    end
  end

  task automatic results();
    if (bad_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Register port: one-cycle strobes, read data in the next cycle
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk({2'b00, rdata & m}, {2'b00, e & m});
  endtask

  task automatic line_in(input logic [7:0] d, input logic stop);
    send_data <= d;
    send_stop <= stop;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    cycles(360);
  endtask

  // Waits for a fresh captured frame
  task automatic take(input logic [7:0] d);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (got_stb !== 1'b1 && n < 1000);
    chk(got, {1'b1, d, 1'b0});
  endtask

  initial
  begin
    resetn = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    irq_mask = 1'b0;
    send = 1'b0;
    send_data = 8'h00;
    send_stop = 1'b1;
    seed = 32'h65abeac5;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    cycles(1);
    chk({9'h000, tx_pin_oe_n}, 10'h001);
    rd(3'h0, 8'hc0, 8'hff);
    rd(3'h5, 8'h00, 8'hff);
    wr(3'h4, 8'h08);
    lows = 0;
    repeat (400)
    begin
      @(posedge clk);
      if (tx_line !== 1'b1)
        lows++;
    end
    #1;
    chk(10'(lows), 10'h000);
    chk({9'h000, tx_pin_oe_n}, 10'h000);
    rx_q.push_back(rnd());
    rx_q.push_back(rnd());
    rd(3'h0, 8'hc0, 8'hc0);
    wr(3'h1, rx_q[0]);
    rd(3'h0, 8'h80, 8'hc0);
    wr(3'h1, rx_q[1]);
    rd(3'h0, 8'h00, 8'h80);
    take(rx_q[0]);
    take(rx_q[1]);
    cycles(40);
    rd(3'h0, 8'hc0, 8'hc0);
    rx_q.delete();
    // Receiver on with its interrupt enabled
    wr(3'h4, 8'h2c);
    rx_q.push_back(rnd());
    line_in(rx_q[0], 1'b1);
    chk({9'h000, irq}, 10'h001);
    irq_mask <= 1'b1;
    cycles(2);
    chk({9'h000, irq}, 10'h000);
    irq_mask <= 1'b0;
    rd(3'h0, 8'h20, 8'h2e);
    rd(3'h1, rx_q.pop_front(), 8'hff);
    rd(3'h0, 8'h00, 8'h2e);
    rx_q.push_back(rnd());
    rx_q.push_back(rnd());
    line_in(rx_q[0], 1'b1);
    line_in(rx_q[1], 1'b1);
    rd(3'h0, 8'h28, 8'h2e);
    rd(3'h1, rx_q[0], 8'hff);
    rd(3'h0, 8'h00, 8'h2e);
    line_in(8'h00, 1'b0);
    rd(3'h0, 8'h22, 8'h22);
    rd(3'h1, 8'h00, 8'hff);
    results();
  end
endmodule // asu_top_test

`default_nettype wire
